/* File: bench/rpsc_slicer_config_props.sv */
// concurrent checks on the slicer configuration ports
`timescale 1ns/1ps
module rpsc_slicer_config_props #(
    parameter int SAMPLE_W = 8
) (
    input wire logic                clk_i,
    input wire logic                resetn_i,
    input wire logic [7:0]          addr_i,
    input wire logic [7:0]          wdata_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic [7:0]          rdata_o,
    input wire logic                rx_start_i,
    input wire logic                wakeup_phase_i,
    input wire logic                preamble_phase_i,
    input wire logic                data_phase_i,
    input wire logic                chip_timeout_i,
    input wire logic                bit_strobe_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic [SAMPLE_W-1:0] threshold_o,
    input wire logic                slice_o,
    input wire logic                edge_mode_o,
    input wire logic [1:0]          gap_count_o,
    input wire logic                acq_busy_o
);
    ////////////////////////////////////////////////////////////////
    logic [7:0] rw, rp;
    logic       pw, pa;
    wire  [7:0] cs = pw ? rw : rp;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            {rw, rp, pw, pa} <= 18'h00000;
        end else begin
            if (wr_i && addr_i == 8'h2B) rw <= wdata_i;
            if (wr_i && addr_i == 8'h2C) rp <= wdata_i;
            pw <= wakeup_phase_i;
            pa <= wakeup_phase_i | preamble_phase_i | data_phase_i;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_acq_req;
        rx_start_i && pa && cs[3] && cs[1:0] != 2'h0;
    endsequence
    a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside answer cycle");
    a_gap_sel: assert property (gap_count_o == cs[7:6])
        else $error("gap count not from active set");
    a_edge_sel: assert property (edge_mode_o == (cs[5:4] == 2'h0))
        else $error("edge mode not from active set");
    a_thr_hold: assert property (cs[5:4] == 2'h1 && cs[3:2] == 2'h0 && !acq_busy_o
        |=> $stable(threshold_o)) else $error("held threshold moved");
    a_acq_start: assert property (s_acq_req |=> acq_busy_o)
        else $error("acquisition not started");
    a_acq_off: assert property (rx_start_i && cs[1:0] == 2'h0 && !acq_busy_o
        && !chip_timeout_i |=> !acq_busy_o) else $error("zero length acquisition ran");
    a_to_restart: assert property (chip_timeout_i && pa && cs[3:2] == 2'h3
        && cs[1:0] != 2'h0 |=> acq_busy_o) else $error("no restart on timeout");
    a_idle_noacq: assert property (!pa && !acq_busy_o |=> !acq_busy_o)
        else $error("acquisition started while idle");
    a_level_slice: assert property (cs[5:4] != 2'h0
        |=> slice_o == ($past(sample_i) >= $past(threshold_o)))
        else $error("level slicer output wrong");
endmodule
bind rpsc_slicer_config rpsc_slicer_config_props #(.SAMPLE_W(SAMPLE_W)) u_props (.*);

/* File: bench/rpsc_slicer_config_tb.sv */
// self-checking bench of the slicer configuration block
`timescale 1ns/1ps
module rpsc_slicer_config_tb;
    import rpsc_pkg::*;
    logic       clk_i, resetn_i, wr_i, rd_i, rx_start_i, chip_timeout_i, bit_strobe_i;
    logic [7:0] addr_i, wdata_i, rdata_o, sample_i, threshold_o, cur, got, ex, s;
    logic [2:0] ph;
    logic [1:0] gap_count_o;
    logic       slice_o, edge_mode_o, acq_busy_o, rd_d, lk;
    logic [10:0] sum;
    logic [7:0] eq[$];
    int         num_errors, n_tests, seed, i, p;
    rpsc_slicer_config uut (.wakeup_phase_i(ph[0]), .preamble_phase_i(ph[1]),
        .data_phase_i(ph[2]), .*);
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task report_and_stop;
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_i); wr_i <= 1'b0; @(posedge clk_i);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        eq.push_back(e); addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i); rd_i <= 1'b0; @(posedge clk_i);
    endtask
    task look(input logic [7:0] e);
        eq.push_back(e); lk <= 1'b1;
        @(posedge clk_i); lk <= 1'b0; @(posedge clk_i);
    endtask
    task pulse_start;
        rx_start_i <= 1'b1; @(posedge clk_i); rx_start_i <= 1'b0; @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d || lk) begin
            got = rd_d ? rdata_o : threshold_o;
            ex = eq.pop_front();
            n_tests++;
            if (got !== ex) begin
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
                num_errors++;
            end
        end
    end
    initial begin
        #50000; num_errors++; report_and_stop();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {resetn_i, wr_i, rd_i, rx_start_i, chip_timeout_i, bit_strobe_i, lk, rd_d} = 8'h00;
        {addr_i, wdata_i, sample_i, ph} = 27'h0; seed = 32'h9a5616f7;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1; @(posedge clk_i);
        rd(8'h2B, 8'h00); rd(8'h2C, 8'h00); rd(8'h30, 8'h00); rd(8'h40, 8'h00);
        for (i = 0; i < 6; i++) begin
            s = 8'($random(seed));
            wr(8'h2B + 8'(i % 3 + i / 3 * 3), s);
            rd(8'h2B + 8'(i % 3 + i / 3 * 3), (i < 2 || i == 5) ? s : 8'h00);
        end
        cur = 8'($random(seed)); wr(8'h30, cur); wr(8'h2B, 8'h14);
        ph <= 3'b001; @(posedge clk_i); pulse_start(); look(cur);
        for (p = 0; p < 3; p++) begin
            ph <= 3'b000; wr(p == 0 ? 8'h2B : 8'h2C, 8'h08 | 8'(p + 1));
            ph <= 3'(1 << p); @(posedge clk_i); pulse_start(); sum = 11'h000;
            for (i = 0; i < (2 << p); i++) begin
                s = 8'($random(seed)); sum += 11'(s);
                sample_i <= s; bit_strobe_i <= 1'b1; @(posedge clk_i);
            end
            bit_strobe_i <= 1'b0; cur = 8'(sum >> (p + 1));
            look(cur);
            rd(8'h30, cur);
        end
        ph <= 3'b000; wr(8'h2B, 8'h1D); ph <= 3'b001; @(posedge clk_i);
        chip_timeout_i <= 1'b1; @(posedge clk_i); chip_timeout_i <= 1'b0; @(posedge clk_i);
        rd(8'h31, 8'h12);
        resetn_i <= 1'b0; repeat (2) @(posedge clk_i); resetn_i <= 1'b1; @(posedge clk_i);
        rd(8'h2B, 8'h00); cur = 8'h00;
        for (p = 1; p < 4; p++) begin
            wr(8'h2B, 8'(p << 4)); sample_i <= 8'hFF; bit_strobe_i <= 1'b1;
            @(posedge clk_i); bit_strobe_i <= 1'b0;
            if (p > 1) cur = cur + ((8'hFF - cur) >> (p == 2 ? 2 : 4));
            look(cur);
        end
        report_and_stop();
    end
endmodule

/* File: core/rpsc_slicer_config.sv */
// wakeup and preamble data slicer configuration (preamble set also serves data phase), threshold acquisition and register port
`timescale 1ns/1ps
`include "rpsc_map.svh"

module rpsc_slicer_config
    import rpsc_pkg::*;
#(
    parameter int SAMPLE_W = 8
) (
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire logic [7:0]          addr_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [7:0]          rdata_o,
    input  wire logic                rx_start_i,
    input  wire logic                wakeup_phase_i,
    input  wire logic                preamble_phase_i,
    input  wire logic                data_phase_i,
    input  wire logic                chip_timeout_i,
    input  wire logic                bit_strobe_i,
    input  wire logic [SAMPLE_W-1:0] sample_i,
    output logic      [SAMPLE_W-1:0] threshold_o,
    output logic                     slice_o,
    output logic                     edge_mode_o,
    output logic      [1:0]          gap_count_o,
    output logic                     acq_busy_o
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]          wakeup_slicer_control;
    logic [7:0]          preamble_slicer_control;
    logic [7:0]          slicer_initial_threshold;
    rpsc_phase_e         phase;
    rpsc_phase_e         next_phase;
    logic [SAMPLE_W-1:0] threshold;
    logic [SAMPLE_W+3:0] acq_sum;
    logic [3:0]          acq_cnt;
    logic                acq_run;
    logic                slice;

    ////////////////////////////////////////////////////////////////////////////
    // field extraction and decode
    function automatic logic [3:0] acq_bits(input logic [1:0] len);
        case (len)
            2'h1:    acq_bits = 4'h2;
            2'h2:    acq_bits = 4'h4;
            2'h3:    acq_bits = 4'h8;
            default: acq_bits = 4'h0;
        endcase
    endfunction

    wire logic        sel_wakeup = (phase == RPSC_PH_WAKEUP);
    wire logic [7:0]  ctrl       = sel_wakeup ? wakeup_slicer_control
                                              : preamble_slicer_control;
    wire logic [1:0]  wakeup_gap_count              = wakeup_slicer_control[`RPSC_GAP_MSB:`RPSC_GAP_LSB];
    wire logic [1:0]  preamble_gap_count            = preamble_slicer_control[`RPSC_GAP_MSB:`RPSC_GAP_LSB];
    wire rpsc_slicer_e slicer_type = rpsc_slicer_e'(ctrl[`RPSC_TYPE_MSB:`RPSC_TYPE_LSB]);
    wire rpsc_init_e   init_mode   = rpsc_init_e'(ctrl[`RPSC_INIT_MSB:`RPSC_INIT_LSB]);
    wire logic [3:0]  acq_len     = acq_bits(ctrl[`RPSC_ACQ_MSB:`RPSC_ACQ_LSB]);
    wire logic        rx_active   = (phase != RPSC_PH_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // phase tracking
    always_comb begin
        case (1'b1)
            wakeup_phase_i:   next_phase = RPSC_PH_WAKEUP;
            preamble_phase_i: next_phase = RPSC_PH_PREAMBLE;
            data_phase_i:     next_phase = RPSC_PH_DATA;
            default:          next_phase = RPSC_PH_IDLE;
        endcase
    end

    wire logic acq_mode    = (init_mode == RPSC_INIT_ACQ) || (init_mode == RPSC_INIT_ACQ_TO);
    wire logic acq_enabled = acq_mode && (acq_len != 4'h0) && rx_active;
    wire logic acq_start   = rx_start_i && acq_enabled
                          || (init_mode == RPSC_INIT_ACQ_TO) && chip_timeout_i && acq_enabled;
    wire logic acq_last    = acq_run && bit_strobe_i && (acq_cnt == acq_len - 4'h1);
    wire logic [SAMPLE_W+3:0] acq_total = acq_sum + {4'h0, sample_i};

    // average by shift: 2, 4, 8 samples
    wire logic [SAMPLE_W-1:0] acq_avg =
        (acq_len == 4'h2) ? acq_total[SAMPLE_W:1] :
        (acq_len == 4'h4) ? acq_total[SAMPLE_W+1:2] : acq_total[SAMPLE_W+2:3];

    // threshold low-pass step: thr += (sample - thr) >> k
    wire logic [3:0]          lpf_k   = (slicer_type == RPSC_SLICE_LPF4) ? `RPSC_LPF_SHIFT_SHORT
                                                                         : `RPSC_LPF_SHIFT_LONG;
    wire logic signed [SAMPLE_W:0] lpf_diff = $signed({1'b0, sample_i}) - $signed({1'b0, threshold});
    wire logic signed [SAMPLE_W:0] lpf_step = lpf_diff >>> lpf_k;
    wire logic [SAMPLE_W:0]   lpf_sum = {1'b0, threshold} + lpf_step;
    wire logic lpf_on = rx_active && bit_strobe_i && !acq_run
                     && (slicer_type == RPSC_SLICE_LPF4 || slicer_type == RPSC_SLICE_LPF16);

    ////////////////////////////////////////////////////////////////////////////
    // register port
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wakeup_slicer_control    <= `RPSC_CTRL_RESET;
            preamble_slicer_control  <= `RPSC_CTRL_RESET;
        end else if (wr_i && addr_i == `RPSC_ADDR_WAKEUP_CTRL) begin
            wakeup_slicer_control    <= wdata_i;
        end else if (wr_i && addr_i == `RPSC_ADDR_PREAMBLE_CTRL) begin
            preamble_slicer_control  <= wdata_i;
        end
    end

    // hardware result wins over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            slicer_initial_threshold <= `RPSC_THRESH_RESET;
        end else if (acq_last) begin
            slicer_initial_threshold <= 8'(acq_avg);
        end else if (wr_i && addr_i == `RPSC_ADDR_INIT_THRESH) begin
            slicer_initial_threshold <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `RPSC_ADDR_WAKEUP_CTRL:   rdata_o <= wakeup_slicer_control;
                `RPSC_ADDR_PREAMBLE_CTRL: rdata_o <= preamble_slicer_control;
                `RPSC_ADDR_INIT_THRESH:   rdata_o <= slicer_initial_threshold;
                `RPSC_ADDR_STATUS:        rdata_o <= {3'h0, acq_run, phase};
                default:                  rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // acquisition and threshold
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phase   <= RPSC_PH_IDLE;
            acq_run <= 1'b0;
            acq_cnt <= 4'h0;
            acq_sum <= '0;
        end else begin
            phase <= next_phase;
            if (acq_start) begin
                acq_run <= 1'b1;
                acq_cnt <= 4'h0;
                acq_sum <= '0;
            end else if (!rx_active) begin
                acq_run <= 1'b0;
            end else if (acq_run && bit_strobe_i) begin
                acq_cnt <= acq_last ? 4'h0 : acq_cnt + 4'h1;
                acq_sum <= acq_last ? '0 : acq_total;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            threshold <= '0;
        end else if (rx_start_i && init_mode == RPSC_INIT_REG) begin
            threshold <= SAMPLE_W'(slicer_initial_threshold);
        end else if (acq_last) begin
            threshold <= acq_avg;
        end else if (lpf_on) begin
            threshold <= lpf_sum[SAMPLE_W-1:0];
        end
        // otherwise held, as for the non-filtered level slicer
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            slice <= 1'b0;
        end else if (slicer_type != RPSC_SLICE_EDGE) begin
            slice <= (sample_i >= threshold);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign threshold_o = threshold;
    assign slice_o     = slice;
    assign edge_mode_o = (slicer_type == RPSC_SLICE_EDGE);
    assign gap_count_o = sel_wakeup ? wakeup_gap_count : preamble_gap_count;
    assign acq_busy_o  = acq_run;

endmodule

/* File: inc/rpsc_map.svh */
// register offsets, field positions, reset values and low-pass shift amounts of the slicer config
`ifndef RPSC_MAP_SVH
`define RPSC_MAP_SVH
`define RPSC_ADDR_WAKEUP_CTRL    8'h2B
`define RPSC_ADDR_PREAMBLE_CTRL  8'h2C
`define RPSC_ADDR_INIT_THRESH    8'h30
`define RPSC_ADDR_STATUS         8'h31
`define RPSC_GAP_MSB             7
`define RPSC_GAP_LSB             6
`define RPSC_TYPE_MSB            5
`define RPSC_TYPE_LSB            4
`define RPSC_INIT_MSB            3
`define RPSC_INIT_LSB            2
`define RPSC_ACQ_MSB             1
`define RPSC_ACQ_LSB             0
`define RPSC_CTRL_RESET          8'h00
`define RPSC_THRESH_RESET        8'h00
`define RPSC_LPF_SHIFT_SHORT     4'h2
`define RPSC_LPF_SHIFT_LONG      4'h4
`endif

/* File: inc/rpsc_pkg.sv */
// types of the slicer configuration block
package rpsc_pkg;
    typedef enum logic [1:0] {
        RPSC_SLICE_EDGE   = 2'h0,
        RPSC_SLICE_HOLD   = 2'h1,
        RPSC_SLICE_LPF4   = 2'h2,
        RPSC_SLICE_LPF16  = 2'h3
    } rpsc_slicer_e;
    typedef enum logic [1:0] {
        RPSC_INIT_NONE    = 2'h0,
        RPSC_INIT_REG     = 2'h1,
        RPSC_INIT_ACQ     = 2'h2,
        RPSC_INIT_ACQ_TO  = 2'h3
    } rpsc_init_e;
    typedef enum logic [3:0] {
        RPSC_PH_IDLE      = 4'b0001,
        RPSC_PH_WAKEUP    = 4'b0010,
        RPSC_PH_PREAMBLE  = 4'b0100,
        RPSC_PH_DATA      = 4'b1000
    } rpsc_phase_e;
endpackage
